// ===== rtl/nrc_defs.svh
// constants of the namespace reservation checker
`ifndef NRC_DEFS_SVH
`define NRC_DEFS_SVH

`define NRC_NS_CNT 4
`define NRC_NS_W 2
`define NRC_HOST_CNT 4
`define NRC_HOST_W 2
`define NRC_ENTRY_CNT 16
`define NRC_KEY_W 64
`define NRC_KIND_CNT 3
`define NRC_NAMESPACE_IDENTIFIER_ALL 32'hFFFF_FFFF
`define NRC_NAMESPACE_IDENTIFIER_ZERO 32'h0000_0000
`define NRC_NAMESPACE_IDENTIFIER_ONE 32'h0000_0001
`define NRC_NAMESPACE_IDENTIFIER_MAX 32'h0000_0004
`define NRC_ACT_REGISTER 3'h0
`define NRC_ACT_REPLACE 3'h2
`define NRC_PTPL_CHANGE_BIT 1
`define NRC_PTPL_VALUE_BIT 0

`endif

// ===== rtl/nrc_pkg.sv
// types of the namespace reservation checker
package nrc_pkg;

  // reservation types
  typedef enum logic [2:0] {
    NRC_RT_WR_EXCL,
    NRC_RT_EXCL_ACC,
    NRC_RT_WR_EXCL_REG,
    NRC_RT_EXCL_ACC_REG,
    NRC_RT_WR_EXCL_ALL,
    NRC_RT_EXCL_ACC_ALL
  } nrc_rtype_e;

  // command classes seen by the access check
  typedef enum logic [2:0] {
    NRC_CMD_READ_GRP,
    NRC_CMD_WRITE_GRP,
    NRC_CMD_ACQUIRE,
    NRC_CMD_HOLDER_OPS,
    NRC_CMD_REGISTER,
    NRC_CMD_REPORT,
    NRC_CMD_OTHER
  } nrc_cmd_e;

  // completion status
  typedef enum logic [1:0] {
    NRC_ST_OK,
    NRC_ST_CONFLICT,
    NRC_ST_BAD_OPCODE,
    NRC_ST_BAD_FIELD
  } nrc_status_e;

  // notification kinds
  typedef enum logic [1:0] {
    NRC_NT_REG_PREEMPTED,
    NRC_NT_RES_RELEASED,
    NRC_NT_RES_PREEMPTED
  } nrc_notif_e;

endpackage : nrc_pkg

// ===== rtl/nrc_key_table.sv
// per namespace, per host registration keys
`timescale 1ns/100ps
`default_nettype none
`include "nrc_defs.svh"

module nrc_key_table (
  input wire logic core_clk,
  input wire logic nv_init,
  input wire logic power_loss,
  input wire logic [`NRC_NS_CNT-1:0] keep_ns,
  input wire logic wr_en,
  input wire logic [`NRC_NS_W-1:0] wr_ns,
  input wire logic [`NRC_HOST_W-1:0] wr_host,
  input wire logic [`NRC_KEY_W-1:0] wr_key,
  input wire logic [`NRC_NS_W-1:0] rd_ns,
  input wire logic [`NRC_HOST_W-1:0] rd_host,
  output logic [`NRC_KEY_W-1:0] rd_key,
  output logic [`NRC_ENTRY_CNT-1:0] valid_map
);

  logic [`NRC_KEY_W-1:0] key_reg [`NRC_ENTRY_CNT];
  logic [`NRC_ENTRY_CNT-1:0] valid_reg;
  logic [`NRC_NS_W+`NRC_HOST_W-1:0] wr_idx;
  logic [`NRC_NS_W+`NRC_HOST_W-1:0] rd_idx;

  // entry index is namespace then host, so one host id maps one entry per namespace
  assign wr_idx = {wr_ns, wr_host};
  assign rd_idx = {rd_ns, rd_host};
  assign rd_key = key_reg[rd_idx];
  assign valid_map = valid_reg;

  // entries survive controller resets; only nv_init, or power loss on a namespace not in keep_ns, wipes them
  genvar e;
  generate
    for (e = 0; e < `NRC_ENTRY_CNT; e++) begin : g_entry
      logic hit;
      logic wipe;
      assign hit = wr_en && (wr_idx == e[`NRC_NS_W+`NRC_HOST_W-1:0]);
      assign wipe = nv_init ||
        (power_loss && !keep_ns[e / `NRC_HOST_CNT]);
      always_ff @(posedge core_clk) begin
        if (wipe) begin
          valid_reg[e] <= 1'b0;
        end else if (hit) begin
          valid_reg[e] <= 1'b1;
        end
      end
      always_ff @(posedge core_clk) begin
        if (nv_init) begin
          key_reg[e] <= '0;
        end else if (hit) begin
          key_reg[e] <= wr_key;
        end
      end
    end
  endgenerate

endmodule : nrc_key_table
`default_nettype wire

// ===== rtl/nrc_checker.sv
// namespace reservation checker: registration, access check, notices
//
// Summary of operation
// - three notice kinds: registration preempted, reservation released, preempted
// - an unmasked notice on a namespace yields a log entry
// - masks per kind and per namespace; masked notices give no entry
// - registration is keyed by host id, shared by all its controllers
// - register action 000b stores the new key for the host
// - repeated same key is accepted; keys need not be unique
// - register action ignores the ignore-existing-key bit
// - registrant registering a different key gets a conflict
// - replace action 010b swaps in the new key
// - replaced key is seen by every controller with that host id
// - replace with wrong current key gets a conflict
// - ignore-existing-key set makes replace always succeed
// - replacing a key leaves the reservation untouched
// - six reservation types; all-registrants forms make registrants holders
// - read group access depends on type and registration
// - write group conflicts for all but the holder under plain types
// - acquire conflicts whenever a reservation exists
// - release and preempt need registration; others always allowed
// - allowed commands complete ok, others with conflict
// - state survives controller resets, lost only on power loss or nv_init
// - persist state per namespace keeps state over power loss
// - all-namespace non-reservation command conflicts if any reserved namespace denies it
// - reservation command to unsupporting namespace gets invalid opcode
`timescale 1ns/100ps
`default_nettype none
`include "nrc_defs.svh"

module nrc_checker
  import nrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic nv_init,
  input wire logic power_loss,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [`NRC_HOST_W-1:0] cmd_host_id,
  input wire logic [31:0] cmd_namespace_identifier,
  input wire nrc_cmd_e cmd_class,
  input wire logic [2:0] register_action_field,
  input wire logic [`NRC_KEY_W-1:0] new_key_field,
  input wire logic [`NRC_KEY_W-1:0] current_key_field,
  input wire logic ignore_existing_key_bit,
  input wire logic [1:0] cmd_ptpl_ctl,
  input wire logic [`NRC_NS_CNT-1:0] ns_resv_support,
  input wire logic rsv_upd_valid,
  input wire logic [`NRC_NS_W-1:0] rsv_upd_ns,
  input wire logic rsv_upd_release,
  input wire nrc_rtype_e rsv_upd_type,
  input wire logic [`NRC_HOST_W-1:0] rsv_upd_holder,
  input wire logic feat_ptpl_we,
  input wire logic [`NRC_NS_W-1:0] feat_ptpl_ns,
  input wire logic feat_ptpl_val,
  input wire logic evt_valid,
  input wire logic [`NRC_NS_W-1:0] evt_ns,
  input wire nrc_notif_e evt_kind,
  input wire logic [`NRC_NS_CNT*`NRC_KIND_CNT-1:0] notif_mask,
  output logic rsp_valid,
  output nrc_status_e rsp_status,
  output logic [`NRC_HOST_W-1:0] rsp_host_id,
  output logic log_valid,
  output logic [`NRC_NS_W-1:0] log_ns,
  output nrc_notif_e log_kind,
  output logic [`NRC_NS_CNT-1:0] power_loss_persist_state,
  output logic [`NRC_NS_CNT-1:0] rsv_active,
  output logic [`NRC_ENTRY_CNT-1:0] registrant_map
);

  // reservation and persist state, kept over controller resets
  logic [`NRC_NS_CNT-1:0] rsv_active_reg;
  nrc_rtype_e rsv_type_reg [`NRC_NS_CNT];
  logic [`NRC_HOST_W-1:0] rsv_holder_reg [`NRC_NS_CNT];
  logic [`NRC_NS_CNT-1:0] ptpl_reg;

  // answer and log registers
  logic rsp_valid_reg;
  nrc_status_e rsp_status_reg;
  nrc_status_e rsp_status_next;
  logic [`NRC_HOST_W-1:0] rsp_host_reg;
  logic log_valid_reg;
  logic log_valid_next;
  logic [`NRC_NS_W-1:0] log_ns_reg;
  nrc_notif_e log_kind_reg;

  // decode wires
  logic [31:0] namespace_identifier_m1;
  logic [`NRC_NS_W-1:0] sel_ns;
  logic ns_in_range;
  logic namespace_identifier_all;
  logic is_rsv_cmd;
  logic sel_reg;
  logic [`NRC_KEY_W-1:0] sel_key;
  logic key_eq_new;
  logic key_eq_cur;
  logic act_register;
  logic act_replace;
  logic register_fail;
  logic replace_fail;
  logic [`NRC_NS_CNT-1:0] ns_allowed;
  logic any_denied;
  logic key_wr_en;
  logic [`NRC_NS_CNT-1:0] keep_ns;

  // the checker never stalls a command
  assign cmd_ready = 1'b1;

  // namespace select; identifiers count from one
  assign namespace_identifier_m1 = cmd_namespace_identifier - `NRC_NAMESPACE_IDENTIFIER_ONE;
  assign sel_ns = namespace_identifier_m1[`NRC_NS_W-1:0];
  assign namespace_identifier_all = (cmd_namespace_identifier == `NRC_NAMESPACE_IDENTIFIER_ALL);
  assign ns_in_range = (cmd_namespace_identifier != `NRC_NAMESPACE_IDENTIFIER_ZERO) &&
    (cmd_namespace_identifier <= `NRC_NAMESPACE_IDENTIFIER_MAX);
  assign is_rsv_cmd = (cmd_class == NRC_CMD_ACQUIRE) ||
    (cmd_class == NRC_CMD_HOLDER_OPS) || (cmd_class == NRC_CMD_REGISTER) ||
    (cmd_class == NRC_CMD_REPORT);

  // registration of the issuing host on the selected namespace
  assign sel_reg = registrant_map[{sel_ns, cmd_host_id}];
  assign key_eq_new = (sel_key == new_key_field);
  assign key_eq_cur = (sel_key == current_key_field);
  assign act_register = (register_action_field == `NRC_ACT_REGISTER);
  assign act_replace = (register_action_field == `NRC_ACT_REPLACE);

  // register: only a different key from a registrant fails
  assign register_fail = sel_reg && !key_eq_new;
  // replace: key must match unless the ignore bit is set
  assign replace_fail = !ignore_existing_key_bit &&
    (!sel_reg || !key_eq_cur);

  // access check for every namespace, used by single and all-ns commands
  genvar i;
  generate
    for (i = 0; i < `NRC_NS_CNT; i++) begin : g_ns
      logic is_reg;
      logic all_reg_type;
      logic plain_type;
      logic excl_acc;
      logic holder;
      logic read_ok;
      logic write_ok;
      logic class_ok;
      assign is_reg = registrant_map[{i[`NRC_NS_W-1:0], cmd_host_id}];
      assign all_reg_type = (rsv_type_reg[i] == NRC_RT_WR_EXCL_ALL) ||
        (rsv_type_reg[i] == NRC_RT_EXCL_ACC_ALL);
      assign plain_type = (rsv_type_reg[i] == NRC_RT_WR_EXCL) ||
        (rsv_type_reg[i] == NRC_RT_EXCL_ACC);
      assign excl_acc = (rsv_type_reg[i] == NRC_RT_EXCL_ACC) ||
        (rsv_type_reg[i] == NRC_RT_EXCL_ACC_REG) ||
        (rsv_type_reg[i] == NRC_RT_EXCL_ACC_ALL);
      // every registrant holds an all-registrants reservation
      assign holder = all_reg_type ? is_reg :
        (is_reg && (rsv_holder_reg[i] == cmd_host_id));
      assign read_ok = !excl_acc || holder ||
        (is_reg && !plain_type);
      assign write_ok = holder || (is_reg && !plain_type);
      assign class_ok =
        (cmd_class == NRC_CMD_READ_GRP) ? read_ok :
        (cmd_class == NRC_CMD_WRITE_GRP) ? write_ok :
        (cmd_class == NRC_CMD_ACQUIRE) ? 1'b0 :
        (cmd_class == NRC_CMD_HOLDER_OPS) ? is_reg :
        1'b1;
      assign ns_allowed[i] = !rsv_active_reg[i] || class_ok;
    end
  endgenerate

  // an all-namespace command fails if any reserved namespace denies it
  assign any_denied = ~&ns_allowed;

  // completion status of the command in hand
  always_comb begin
    rsp_status_next = NRC_ST_OK;
    if (namespace_identifier_all) begin
      if (is_rsv_cmd) begin
        rsp_status_next = NRC_ST_BAD_FIELD;
      end else if (any_denied) begin
        rsp_status_next = NRC_ST_CONFLICT;
      end
    end else if (!ns_in_range) begin
      rsp_status_next = NRC_ST_BAD_FIELD;
    end else if (is_rsv_cmd && !ns_resv_support[sel_ns]) begin
      rsp_status_next = NRC_ST_BAD_OPCODE;
    end else if (cmd_class == NRC_CMD_REGISTER) begin
      if (act_register) begin
        rsp_status_next = register_fail ? NRC_ST_CONFLICT : NRC_ST_OK;
      end else if (act_replace) begin
        rsp_status_next = replace_fail ? NRC_ST_CONFLICT : NRC_ST_OK;
      end else begin
        rsp_status_next = NRC_ST_BAD_FIELD;
      end
    end else if (!ns_allowed[sel_ns]) begin
      rsp_status_next = NRC_ST_CONFLICT;
    end
  end

  // a good register or replace writes the new key for the host
  assign key_wr_en = cmd_valid && !namespace_identifier_all && ns_in_range &&
    (cmd_class == NRC_CMD_REGISTER) && (rsp_status_next == NRC_ST_OK);
  // namespaces that keep their state over power loss
  assign keep_ns = ptpl_reg;

  // key store, indexed by namespace and host id
  nrc_key_table u_key_table (
    .core_clk(core_clk),
    .nv_init(nv_init),
    .power_loss(power_loss),
    .keep_ns(keep_ns),
    .wr_en(key_wr_en),
    .wr_ns(sel_ns),
    .wr_host(cmd_host_id),
    .wr_key(new_key_field),
    .rd_ns(sel_ns),
    .rd_host(cmd_host_id),
    .rd_key(sel_key),
    .valid_map(registrant_map)
  );

  // reservation state, changed only by the acquire and release engine, wiped by nv_init or by power loss where ptpl_reg is clear
  generate
    for (i = 0; i < `NRC_NS_CNT; i++) begin : g_rsv
      logic upd_hit;
      logic wipe;
      assign upd_hit = rsv_upd_valid && (rsv_upd_ns == i[`NRC_NS_W-1:0]);
      assign wipe = nv_init || (power_loss && !ptpl_reg[i]);
      always_ff @(posedge core_clk) begin
        if (wipe) begin
          rsv_active_reg[i] <= 1'b0;
        end else if (upd_hit) begin
          rsv_active_reg[i] <= !rsv_upd_release;
        end
      end
      always_ff @(posedge core_clk) begin
        if (nv_init) begin
          rsv_type_reg[i] <= NRC_RT_WR_EXCL;
          rsv_holder_reg[i] <= '0;
        end else if (upd_hit && !rsv_upd_release) begin
          rsv_type_reg[i] <= rsv_upd_type;
          rsv_holder_reg[i] <= rsv_upd_holder;
        end
      end
    end
  endgenerate

  // persist state: set by register side effect or by a feature write
  generate
    for (i = 0; i < `NRC_NS_CNT; i++) begin : g_ptpl
      logic cmd_hit;
      logic feat_hit;
      assign cmd_hit = key_wr_en && (sel_ns == i[`NRC_NS_W-1:0]) &&
        cmd_ptpl_ctl[`NRC_PTPL_CHANGE_BIT];
      assign feat_hit = feat_ptpl_we &&
        (feat_ptpl_ns == i[`NRC_NS_W-1:0]);
      always_ff @(posedge core_clk) begin
        if (nv_init) begin
          ptpl_reg[i] <= 1'b0;
        end else if (cmd_hit) begin
          ptpl_reg[i] <= cmd_ptpl_ctl[`NRC_PTPL_VALUE_BIT];
        end else if (feat_hit) begin
          ptpl_reg[i] <= feat_ptpl_val;
        end
      end
    end
  endgenerate

  // notice gating by per kind, per namespace mask
  assign log_valid_next = evt_valid &&
    !notif_mask[evt_ns * `NRC_KIND_CNT + evt_kind];

  // completion answer, one cycle after the command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_status_reg <= NRC_ST_OK;
      rsp_host_reg <= '0;
    end else begin
      rsp_valid_reg <= cmd_valid;
      rsp_status_reg <= rsp_status_next;
      rsp_host_reg <= cmd_host_id;
    end
  end

  // notice log entry strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      log_valid_reg <= 1'b0;
      log_ns_reg <= '0;
      log_kind_reg <= NRC_NT_REG_PREEMPTED;
    end else begin
      log_valid_reg <= log_valid_next;
      log_ns_reg <= evt_ns;
      log_kind_reg <= evt_kind;
    end
  end

  // outputs
  assign rsp_valid = rsp_valid_reg;
  assign rsp_status = rsp_status_reg;
  assign rsp_host_id = rsp_host_reg;
  assign log_valid = log_valid_reg;
  assign log_ns = log_ns_reg;
  assign log_kind = log_kind_reg;
  assign power_loss_persist_state = ptpl_reg;
  assign rsv_active = rsv_active_reg;

  // checks on the command path and the notice path
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic single_ok;
  assign single_ok = cmd_valid && !namespace_identifier_all && ns_in_range;

  a_rsp_follows_cmd: assert property (
    cmd_valid |=> rsp_valid && rsp_host_id == $past(cmd_host_id))
    else $error("answer missing after command");

  a_write_plain_conflict: assert property (
    single_ok && cmd_class == NRC_CMD_WRITE_GRP &&
    rsv_active_reg[sel_ns] && !sel_reg &&
    rsv_type_reg[sel_ns] == NRC_RT_WR_EXCL
    |=> rsp_status == NRC_ST_CONFLICT)
    else $error("write by non-registrant not refused");

  a_read_excl_nonreg: assert property (
    single_ok && cmd_class == NRC_CMD_READ_GRP &&
    rsv_active_reg[sel_ns] && !sel_reg &&
    rsv_type_reg[sel_ns] == NRC_RT_EXCL_ACC_REG
    |=> rsp_status == NRC_ST_CONFLICT)
    else $error("read by non-registrant not refused");

  a_read_we_allowed: assert property (
    single_ok && cmd_class == NRC_CMD_READ_GRP &&
    rsv_type_reg[sel_ns] == NRC_RT_WR_EXCL
    |=> rsp_status == NRC_ST_OK)
    else $error("read under write exclusive refused");

  a_acquire_conflict: assert property (
    single_ok && cmd_class == NRC_CMD_ACQUIRE &&
    ns_resv_support[sel_ns] && rsv_active_reg[sel_ns]
    |=> rsp_status == NRC_ST_CONFLICT)
    else $error("acquire over reservation not refused");

  a_reg_key_mismatch: assert property (
    single_ok && cmd_class == NRC_CMD_REGISTER && act_register &&
    ns_resv_support[sel_ns] && sel_reg && !key_eq_new
    |-> !key_wr_en ##1 rsp_status == NRC_ST_CONFLICT)
    else $error("different key accepted for registrant");

  a_ignore_existing_key_bit_replace: assert property (
    single_ok && cmd_class == NRC_CMD_REGISTER && act_replace &&
    ns_resv_support[sel_ns] && ignore_existing_key_bit
    |=> rsp_status == NRC_ST_OK)
    else $error("replace with ignore bit refused");

  a_replace_keeps_rsv: assert property (
    key_wr_en && !rsv_upd_valid && !power_loss && !nv_init
    |=> $stable(rsv_active_reg))
    else $error("key replace altered reservation");

  a_no_support_opcode: assert property (
    single_ok && is_rsv_cmd && !ns_resv_support[sel_ns]
    |=> rsp_status == NRC_ST_BAD_OPCODE)
    else $error("unsupported namespace not refused");

  a_masked_no_log: assert property (
    evt_valid && notif_mask[evt_ns * `NRC_KIND_CNT + evt_kind]
    |=> !log_valid)
    else $error("masked notice logged");

  a_unmasked_log: assert property (
    evt_valid && !notif_mask[evt_ns * `NRC_KIND_CNT + evt_kind]
    |=> log_valid && log_ns == $past(evt_ns) &&
        log_kind == $past(evt_kind))
    else $error("unmasked notice not logged");

  c_conflict_seen: cover property (
    cmd_valid ##1 rsp_status == NRC_ST_CONFLICT);
  c_replace_ok: cover property (
    key_wr_en && act_replace);
  c_all_ns_conflict: cover property (
    cmd_valid && namespace_identifier_all && any_denied);
  c_log_entry: cover property (log_valid);

endmodule : nrc_checker
`default_nettype wire

// ===== tb/nrc_host_model.sv
// host side model that issues storage commands to the checker
`timescale 1ns/100ps
`default_nettype none
`include "nrc_defs.svh"

module nrc_host_model
  import nrc_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [`NRC_HOST_W-1:0] cmd_host_id,
  output logic [31:0] cmd_namespace_identifier,
  output nrc_cmd_e cmd_class,
  output logic [2:0] register_action_field,
  output logic [`NRC_KEY_W-1:0] new_key_field,
  output logic [`NRC_KEY_W-1:0] current_key_field,
  output logic ignore_existing_key_bit,
  output logic [1:0] cmd_ptpl_ctl
);
  // quiet request lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_host_id = 2'h0;
    cmd_namespace_identifier = 32'h0000_0000;
    cmd_class = NRC_CMD_OTHER;
    register_action_field = 3'h0;
    new_key_field = 64'h0000_0000_0000_0000;
    current_key_field = 64'h0000_0000_0000_0000;
    ignore_existing_key_bit = 1'b0;
    cmd_ptpl_ctl = 2'h0;
  end

  // one command per edge; fields change just after an edge
  task automatic issue(input logic [1:0] h, input logic [31:0] ns,
                       input nrc_cmd_e c, input logic [2:0] a,
                       input logic [63:0] nk, input logic [63:0] ck,
                       input logic ie, input logic [1:0] pc);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_host_id = h;
    cmd_namespace_identifier = ns;
    cmd_class = c;
    register_action_field = a;
    new_key_field = nk;
    current_key_field = ck;
    ignore_existing_key_bit = ie;
    cmd_ptpl_ctl = pc;
  endtask : issue

  // withdraw; stale keys are scrambled so nothing leans on them
  task automatic idle;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    new_key_field = ~new_key_field;
    current_key_field = ~current_key_field;
  endtask : idle
endmodule : nrc_host_model
`default_nettype wire

// ===== tb/nrc_checker_tb_top.sv
// self-checking bench of the namespace reservation checker
`timescale 1ns/100ps
`default_nettype none

module nrc_checker_tb_top
  import nrc_pkg::*;
;
  logic core_clk, rst, nv_init, power_loss, cmd_valid, cmd_ready;
  logic [1:0] cmd_host_id, cmd_ptpl_ctl, rsv_upd_ns, rsv_upd_holder;
  logic [31:0] cmd_namespace_identifier;
  nrc_cmd_e cmd_class;
  logic [2:0] register_action_field;
  logic [63:0] new_key_field, current_key_field, k0, k1, k2, k3;
  logic ignore_existing_key_bit, rsv_upd_valid, rsv_upd_release;
  logic [3:0] ns_resv_support, power_loss_persist_state, rsv_active;
  nrc_rtype_e rsv_upd_type;
  logic feat_ptpl_we, feat_ptpl_val, evt_valid, rsp_valid, log_valid;
  logic [1:0] feat_ptpl_ns, evt_ns, rsp_host_id, log_ns;
  nrc_notif_e evt_kind, log_kind;
  logic [11:0] notif_mask;
  nrc_status_e rsp_status, ex;
  logic [15:0] registrant_map;
  logic [3:0] exp_q[$];
  logic [3:0] log_q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  nrc_checker i_nrc_checker (.*);

  nrc_host_model i_nrc_host_model (.core_clk(core_clk),
    .cmd_valid(cmd_valid), .cmd_host_id(cmd_host_id),
    .cmd_namespace_identifier(cmd_namespace_identifier),
    .cmd_class(cmd_class), .register_action_field(register_action_field),
    .new_key_field(new_key_field), .current_key_field(current_key_field),
    .ignore_existing_key_bit(ignore_existing_key_bit),
    .cmd_ptpl_ctl(cmd_ptpl_ctl));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic fail(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask : check

  task automatic edge1;
    @(posedge core_clk);
    #1;
  endtask : edge1

  // note the expected answer, then hand the command to the host model
  task automatic cmd(input logic [1:0] h, input logic [31:0] ns,
                     input nrc_cmd_e c, input logic [2:0] a,
                     input logic [63:0] nk, input logic [63:0] ck,
                     input logic ie, input logic [1:0] pc,
                     input nrc_status_e st);
    exp_q.push_back({st, h});
    i_nrc_host_model.issue(h, ns, c, a, nk, ck, ie, pc);
  endtask : cmd

  task automatic rk(input logic [1:0] h, input logic [31:0] ns,
                    input logic [2:0] a, input logic [63:0] nk,
                    input logic [63:0] ck, input logic ie,
                    input nrc_status_e st);
    cmd(h, ns, NRC_CMD_REGISTER, a, nk, ck, ie, 2'h0, st);
  endtask : rk

  task automatic stop;
    i_nrc_host_model.idle();
    edge1();
  endtask : stop

  // access table as seen by a host that does not hold the reservation
  function automatic nrc_status_e exp_acc(input int t, input int c,
                                          input bit r);
    bit cf;
    cf = 1'b0;
    case (c)
      NRC_CMD_READ_GRP: cf = t == NRC_RT_EXCL_ACC || (!r &&
        (t == NRC_RT_EXCL_ACC_REG || t == NRC_RT_EXCL_ACC_ALL));
      NRC_CMD_WRITE_GRP: cf = !r || t == NRC_RT_WR_EXCL ||
        t == NRC_RT_EXCL_ACC;
      NRC_CMD_ACQUIRE: cf = 1'b1;
      NRC_CMD_HOLDER_OPS: cf = !r;
      default: cf = 1'b0;
    endcase
    return cf ? NRC_ST_CONFLICT : NRC_ST_OK;
  endfunction : exp_acc

  // take the oldest note whenever an answer or a log entry shows
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      n_tests++;
      if (exp_q.size() == 0) fail("answer without a command");
      else if ({rsp_status, rsp_host_id} !== exp_q.pop_front())
        fail("answer status or host");
    end
    if (log_valid === 1'b1) begin
      n_tests++;
      if (log_q.size() == 0) fail("log entry for a masked notice");
      else if ({log_ns, log_kind} !== log_q.pop_front())
        fail("log entry namespace or kind");
    end
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail("timeout");
      print_verdict();
    end
  end

  // main sequence
  initial begin
    {rst, nv_init, power_loss, rsv_upd_valid, rsv_upd_release} = 5'h1f;
    {rsv_upd_ns, rsv_upd_holder, feat_ptpl_ns, evt_ns} = 8'h00;
    {feat_ptpl_we, feat_ptpl_val, evt_valid} = 3'h0;
    rsv_upd_type = NRC_RT_WR_EXCL;
    evt_kind = NRC_NT_REG_PREEMPTED;
    notif_mask = 12'h000;
    ns_resv_support = 4'b0111;
    void'($urandom(32'h4a20));
    {k0, k1} = {$urandom, $urandom, $urandom, $urandom};
    {k2, k3} = {$urandom, $urandom, $urandom, $urandom};
    repeat (5) @(posedge core_clk);
    #1;
    {rst, power_loss, rsv_upd_valid, rsv_upd_release} = 4'h0;
    edge1();
    nv_init = 1'b0;
    check(registrant_map, 16'h0000, "map after wipe");
    check({rsv_active, power_loss_persist_state}, 16'h0000, "wiped state");
    check({15'h0000, cmd_ready}, 16'h0001, "ready");
    // registration and replacement, back to back
    rk(0, 1, 3'h0, k0, k3, 0, NRC_ST_OK);
    rk(1, 1, 3'h0, k1, k3, 0, NRC_ST_OK);
    rk(1, 1, 3'h0, k1, k0, 1, NRC_ST_OK);
    rk(3, 1, 3'h0, k1, k2, 0, NRC_ST_OK);
    rk(1, 1, 3'h0, k2, k1, 1, NRC_ST_CONFLICT);
    rk(1, 1, 3'h2, k2, k3, 0, NRC_ST_CONFLICT);
    rk(1, 1, 3'h2, k2, k1, 0, NRC_ST_OK);
    rk(1, 1, 3'h0, k2, k0, 0, NRC_ST_OK);
    rk(1, 1, 3'h0, k1, k0, 0, NRC_ST_CONFLICT);
    rk(2, 2, 3'h2, k3, k0, 1, NRC_ST_OK);
    rk(2, 4, 3'h0, k3, k0, 0, NRC_ST_BAD_OPCODE);
    // field errors: unknown action, namespace zero, report to all
    rk(1, 1, 3'h1, k0, k0, 0, NRC_ST_BAD_FIELD);
    cmd(1, 0, NRC_CMD_OTHER, 3'h0, k0, k0, 0, 2'h0, NRC_ST_BAD_FIELD);
    cmd(1, '1, NRC_CMD_REPORT, 3'h0, k0, k0, 0, 2'h0, NRC_ST_BAD_FIELD);
    stop();
    check(registrant_map, 16'h004b, "registrants by host");
    // every type against every command class but register, registrant and not
    for (int t = 0; t < 6; t++) begin
      rsv_upd_valid = 1'b1;
      rsv_upd_type = nrc_rtype_e'(t);
      edge1();
      rsv_upd_valid = 1'b0;
      edge1();
      check({12'h000, rsv_active}, 16'h0001, "reservation set");
      // host 0 holds single-holder types, host 1 registered, host 2 not
      for (int c = 0; c < 7; c++) begin
        for (int h = 0; h < 3; h++) begin
          if (c != NRC_CMD_REGISTER) begin
            ex = exp_acc(t, c, h != 2);
            if (h == 0 && c < 2) ex = NRC_ST_OK;
            cmd(h[1:0], 1, nrc_cmd_e'(c), 3'($urandom), {$urandom, $urandom},
              {$urandom, $urandom}, 1'($urandom), 2'h0, ex);
          end
        end
      end
      stop();
    end
    // replace under a reservation, then commands to all namespaces
    rk(1, 1, 3'h2, k3, k2, 0, NRC_ST_OK);
    cmd(2, 1, NRC_CMD_READ_GRP, 3'h0, k0, k0, 0, 2'h0, NRC_ST_CONFLICT);
    cmd(2, 32'hffff_ffff, NRC_CMD_WRITE_GRP, 3'h0, k0, k0, 0, 2'h0,
      NRC_ST_CONFLICT);
    cmd(1, 32'hffff_ffff, NRC_CMD_WRITE_GRP, 3'h0, k0, k0, 0, 2'h0,
      NRC_ST_OK);
    stop();
    check({12'h000, rsv_active}, 16'h0001, "reservation kept");
    // persistence: feature write, power loss, register side effect
    {feat_ptpl_we, feat_ptpl_val} = 2'b11;
    edge1();
    feat_ptpl_we = 1'b0;
    edge1();
    check({12'h000, power_loss_persist_state}, 16'h0001, "persist");
    power_loss = 1'b1;
    edge1();
    power_loss = 1'b0;
    edge1();
    check(registrant_map, 16'h000b, "power loss wipe");
    check({12'h000, rsv_active}, 16'h0001, "persisted reservation");
    cmd(2, 2, NRC_CMD_REGISTER, 3'h0, k3, k0, 0, 2'h3, NRC_ST_OK);
    stop();
    check({12'h000, power_loss_persist_state}, 16'h0003, "side effect");
    rst = 1'b1;
    edge1();
    rst = 1'b0;
    edge1();
    check(registrant_map, 16'h004b, "map over reset");
    check({12'h000, rsv_active}, 16'h0001, "reservation over reset");
    // release the reservation; an all-namespace write then passes
    {rsv_upd_valid, rsv_upd_release} = 2'b11;
    edge1();
    rsv_upd_valid = 1'b0;
    edge1();
    check({12'h000, rsv_active}, 16'h0000, "reservation released");
    cmd(2, '1, NRC_CMD_WRITE_GRP, 3'h0, k0, k0, 0, 2'h0, NRC_ST_OK);
    stop();
    // notices of each kind, masked on own or other namespace
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 2; m++) begin
        notif_mask = 12'h001 << (m ? 6 + k : 3 + k);
        evt_ns = 2'h2;
        evt_kind = nrc_notif_e'(k);
        if (m == 0) log_q.push_back({2'h2, 2'(k)});
        evt_valid = 1'b1;
        edge1();
      end
    end
    evt_valid = 1'b0;
    repeat (3) edge1();
    check(16'(exp_q.size() + log_q.size()), 16'h0000, "missing output");
    print_verdict();
  end
endmodule : nrc_checker_tb_top
`default_nettype wire
